// File: rtl/tdp_pkg.sv
// package for the transmit descriptor poll / crc select block
// assumes one 20 MHz clock, avalon-mm register slave, memory master outside
//
// Contract
// - poll enable clear: no new descriptor started; a descriptor already in progress is finished
// - poll enable set: check current descriptor ready
// - not-ready descriptor found: hardware clears poll enable
// - crc select: 0 sixteen-bit, 1 thirty-two-bit
package tdp_pkg;
  localparam logic [3:0]  ADDR_MODE      = 4'h0;  // channel_mode_word
  localparam logic [3:0]  ADDR_STATUS    = 4'h4;  // current descriptor index, busy
  localparam logic [3:0]  ADDR_BASE      = 4'h8;  // descriptor ring base address
  localparam int          POLL_BIT       = 7;
  localparam int          CRC_BIT        = 8;
  localparam logic [15:0] MODE_RESET     = 16'h0000;
  localparam logic [15:0] MODE_WR_MASK   = 16'hF18F;  // bits 4-6, 9-11 reserved
  localparam logic [31:0] BASE_RESET     = 32'h0000_0000;
  localparam int          READY_BIT      = 15;     // ready flag in descriptor status word
  localparam int          WRAP_BIT       = 13;     // last descriptor of the ring
  localparam logic [31:0] DESC_STRIDE    = 32'h0000_0008;

  typedef enum logic [2:0] {
    TDP_IDLE   = 3'b000,
    TDP_RD_ST  = 3'b001,
    TDP_RD_PTR = 3'b010,
    TDP_SEND   = 3'b011,
    TDP_NEXT   = 3'b100
  } tdp_state_type;
endpackage

// File: rtl/tdp_tx_poll.sv
// transmit descriptor poll engine with crc select for one channel
// assumes a memory master port with waitrequest and a send engine
// that accepts a buffer (pointer, length) and reports done
// one instance serves one channel; a multichannel part repeats it
// the poll bit is the only mode field that hardware ever writes
// limitation: descriptors are read one word at a time, no bursts
// limitation: the crc select is only passed on, framing lies outside
// limitation: status read shows the slot index, not the byte address
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
module tdp_tx_poll
  import tdp_pkg::*;
#(
  parameter int RING_SIZE = 8
) (
  input  wire logic        clk,
  input  wire logic        reset,
  // avalon-mm register slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // descriptor memory master
  output logic [31:0]      mem_address,
  output logic             mem_read,
  input  wire logic [31:0] mem_readdata,
  input  wire logic        mem_waitrequest,
  // send engine
  output logic             send_start,
  output logic [31:0]      send_pointer,
  output logic [15:0]      send_length,
  output logic             crc32_select,
  input  wire logic        send_done
);
  import tdp_pkg::*;

  // index is eight bits wide, so the ring holds at most 256 slots
  if (RING_SIZE < 1 || RING_SIZE > 256) begin : g_bad_ring_size
    $error("RING_SIZE out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // walk state
  tdp_state_type state;
  tdp_state_type next_state;
  // register bus and descriptor walk state
  logic [15:0]   mode;
  logic [15:0]   next_mode;
  logic [31:0]   base;
  logic [31:0]   next_base;
  logic [7:0]    index;
  logic [7:0]    next_index;
  logic          wrap;
  logic          next_wrap;
  logic [15:0]   length;
  logic [15:0]   next_length;
  logic [31:0]   pointer;
  logic [31:0]   next_pointer;
  logic          ack;
  logic          next_ack;
  logic [31:0]   rdata;
  logic [31:0]   next_rdata;
  logic          clear_poll;
  logic [15:0]   be_mask;

  // descriptor fields as they come off the memory bus
  logic          desc_ready;
  logic          desc_wrap;
  logic [15:0]   desc_length;
  // walk and register bus conditions
  logic          ring_end;
  logic          busy;
  logic          mode_write;
  logic          sw_poll_set;
  // descriptor address parts
  logic [31:0]   slot_offset;
  logic [31:0]   word_offset;

  assign be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  ////////////////////////////////////////////////////////////////////////
  // descriptor fields and walk conditions
  assign desc_ready  = mem_readdata[READY_BIT];
  assign desc_wrap   = mem_readdata[WRAP_BIT];
  assign desc_length = mem_readdata[31:16];
  // wrap flag ends the ring early; otherwise the last slot wraps to zero
  assign ring_end    = wrap || (index == 8'(RING_SIZE - 1));
  assign busy        = (state != TDP_IDLE);
  // a write lands at the edge that ends its ack cycle, one edge after its wait cycle ends
  assign mode_write  = avs_write && ack && (avs_address == ADDR_MODE);
  assign sw_poll_set = mode_write && avs_byteenable[0] && avs_writedata[POLL_BIT];

  ////////////////////////////////////////////////////////////////////////
  // register slave: one wait cycle for every access, unmapped reads give 0
  always_comb begin
    next_ack   = (avs_read || avs_write) && !ack;
    next_rdata = 32'h0000_0000;
    next_mode  = mode;
    next_base  = base;
    if (avs_read && !ack) begin
      unique case (avs_address)
        ADDR_MODE:   next_rdata = {16'h0000, mode};
        ADDR_STATUS: next_rdata = {23'h00_0000, busy, index};
        ADDR_BASE:   next_rdata = base;
        default:     next_rdata = 32'h0000_0000;
      endcase
    end
    if (mode_write) begin
      next_mode = (mode & ~(be_mask & MODE_WR_MASK))
                | (avs_writedata[15:0] & be_mask & MODE_WR_MASK);
    end
    if (avs_write && ack && avs_address == ADDR_BASE) begin
      next_base = avs_writedata;
    end
    // hardware clear loses only to a software set in the same cycle,
    // so a re-arm racing a not-ready status read is never lost
    if (clear_poll && !sw_poll_set) begin
      next_mode[POLL_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack   <= 1'b0;
      rdata <= 32'h0000_0000;
      mode  <= MODE_RESET;
      base  <= BASE_RESET;
    end else begin
      ack   <= next_ack;
      rdata <= next_rdata;
      mode  <= next_mode;
      base  <= next_base;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign avs_readdata    = rdata;
  assign crc32_select    = mode[CRC_BIT];

  ////////////////////////////////////////////////////////////////////////
  // descriptor walk: status word at +0 (ready, wrap, length), pointer at +4
  // idle waits for the poll bit; status read decides send or stop;
  // pointer read completes the descriptor; send holds until done;
  // next advances the slot and checks the poll bit again, so a
  // cleared bit ends the walk without another memory cycle
  always_comb begin
    next_state   = state;
    next_index   = index;
    next_wrap    = wrap;
    next_length  = length;
    next_pointer = pointer;
    clear_poll   = 1'b0;
    unique case (state)
      TDP_IDLE: begin
        if (mode[POLL_BIT]) begin
          next_state = TDP_RD_ST;
        end
      end
      TDP_RD_ST: begin
        if (!mem_waitrequest) begin
          if (desc_ready) begin
            next_wrap   = desc_wrap;
            next_length = desc_length;
            next_state  = TDP_RD_PTR;
          end else begin
            clear_poll = 1'b1;
            next_state = TDP_IDLE;
          end
        end
      end
      TDP_RD_PTR: begin
        if (!mem_waitrequest) begin
          next_pointer = mem_readdata;
          next_state   = TDP_SEND;
        end
      end
      TDP_SEND: begin
        if (send_done) begin
          next_state = TDP_NEXT;
        end
      end
      TDP_NEXT: begin
        if (ring_end) begin
          next_index = 8'h00;
        end else begin
          next_index = index + 8'h01;
        end
        next_state = mode[POLL_BIT] ? TDP_RD_ST : TDP_IDLE;
      end
      default: next_state = TDP_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state   <= TDP_IDLE;
      index   <= 8'h00;
      wrap    <= 1'b0;
      length  <= 16'h0000;
      pointer <= 32'h0000_0000;
    end else begin
      state   <= next_state;
      index   <= next_index;
      wrap    <= next_wrap;
      length  <= next_length;
      pointer <= next_pointer;
    end
  end

  // no memory cycle at all outside the two read states
  assign mem_read     = (state == TDP_RD_ST) || (state == TDP_RD_PTR);
  // descriptor address: slot offset, plus one word for the pointer read
  assign slot_offset  = {24'h00_0000, index} * DESC_STRIDE;
  assign word_offset  = (state == TDP_RD_PTR) ? 32'h0000_0004 : 32'h0000_0000;
  assign mem_address  = base + slot_offset + word_offset;
  assign send_start   = (state == TDP_SEND);
  assign send_pointer = pointer;
  assign send_length  = length;
endmodule

// File: sim/tdp_monitor.sv
// port checker for tdp_tx_poll
// assumes one clk domain; bound from the bench top file
module tdp_monitor (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] mem_address,
  input wire logic        mem_read,
  input wire logic [31:0] mem_readdata,
  input wire logic        mem_waitrequest,
  input wire logic        send_start,
  input wire logic        send_done,
  input wire logic        crc32_select
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire wr0 = avs_write && !avs_waitrequest && avs_address == 4'h0;
  wire st  = mem_read && !mem_waitrequest && !mem_address[2];
  ////////////////////////////////////////////////////////////////
  property p_crc; wr0 && avs_byteenable[1] |=> crc32_select == $past(avs_writedata[8]); endproperty
  a_crc: assert property (p_crc) else $error("crc select not taken");
  property p_poll; wr0 && avs_byteenable[0] && avs_writedata[7] && !mem_read && !send_start
    |-> ##[1:2] mem_read; endproperty
  a_poll: assert property (p_poll) else $error("no descriptor check");
  property p_stop; st && !mem_readdata[15] |=> !mem_read [*8]; endproperty
  a_stop: assert property (p_stop) else $error("read after not ready");
  property p_fetch; st && mem_readdata[15] |-> ##[2:40] send_start; endproperty
  a_fetch: assert property (p_fetch) else $error("ready buffer not sent");
  property p_hold; send_start && !send_done |=> send_start; endproperty
  a_hold: assert property (p_hold) else $error("send dropped early");
endmodule

// File: sim/tdp_mem_model.sv
// descriptor memory and send engine model
// assumes word index from mem_address[5:2]
module tdp_mem_model (
  input  wire logic        clk,
  input  wire logic [31:0] mem_address,
  input  wire logic        mem_read,
  output logic [31:0]      mem_readdata,
  output logic             mem_waitrequest,
  input  wire logic        send_start,
  output logic             send_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:15];
  int          sends;
  initial begin
    foreach (mem[i]) mem[i] = 0;
    sends = 0;
    mem_waitrequest = 1;
    send_done = 0;
    mem_readdata = 0;
  end
  // forced wait after each ack so a new address never meets stale data
  always @(posedge clk) begin
    mem_waitrequest <= !(mem_read && mem_waitrequest && $urandom_range(1));
    mem_readdata <= mem_read ? mem[mem_address[5:2]] : ~mem_readdata;
    send_done <= send_start && !send_done && $urandom_range(2) == 0;
    if (send_done) sends <= sends + 1;
  end
endmodule

// File: sim/tdp_tx_poll_tb.sv
// self-checking bench for tdp_tx_poll
// assumes tdp_mem_model as far side, tdp_monitor bound below
module tdp_tx_poll_tb;
  import tdp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, reset = 1, avs_read = 0, avs_write = 0;
  logic [3:0]  avs_address = 0, avs_byteenable = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q, mem_address, mem_readdata, send_pointer;
  logic        avs_waitrequest, mem_read, mem_waitrequest, send_start, crc32_select, send_done;
  logic [15:0] send_length;
  int          errors = 0, check_count = 0, n, idx = 0, tot = 0;
  tdp_tx_poll u_tdp_tx_poll (.clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .mem_address,
    .mem_read, .mem_readdata, .mem_waitrequest, .send_start, .send_pointer,
    .send_length, .crc32_select, .send_done);
  tdp_mem_model u_tdp_mem_model (.clk, .mem_address, .mem_read, .mem_readdata,
    .mem_waitrequest, .send_start, .send_done);
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, be, input logic [31:0] d);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge clk);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (send_start && send_done) begin
      chk("send_pointer", u_tdp_mem_model.mem[2 * u_tdp_mem_model.sends + 1],
          send_pointer);
      chk("send_length", {16'h0, u_tdp_mem_model.mem[2 * u_tdp_mem_model.sends][31:16]},
          {16'h0, send_length});
    end
  end
  initial begin
    #400us;
    errors++;
    stop_test;
  end
  initial begin
    void'($urandom(71));
    repeat (8) @(posedge clk);
    reset <= 0;
    bus(0, ADDR_MODE, 4'hF, 0);
    chk("mode reset", {16'h0, MODE_RESET}, q);
    bus(0, 4'hC, 4'hF, 0);
    chk("unmapped", 0, q);
    for (int c = 0; c < 2; c++) begin
      n = $urandom;
      bus(1, ADDR_MODE, 4'b0010, {16'h0, n[15:9], c[0], 8'h00});
      chk("crc32_select", c[0], crc32_select);
      bus(0, ADDR_MODE, 4'hF, 0);
      chk("mode high", {n[15:9], c[0]} & MODE_WR_MASK[15:8], q[15:8]);
    end
    $display("crc select test done");
    for (int r = 0; r < 2; r++) begin
      n = $urandom_range(3, 1);
      for (int i = 0; i < n; i++) begin
        u_tdp_mem_model.mem[2 * (idx + i) + 1] = $urandom;
        u_tdp_mem_model.mem[2 * (idx + i)] = {16'(i + 1), 16'h8000};
      end
      bus(1, ADDR_MODE, 4'b0001, 32'h0000_0080);
      q = 32'hFFFF_FFFF;
      for (int t = 0; t < 200 && q[POLL_BIT] !== 1'b0; t++) bus(0, ADDR_MODE, 4'h3, 0);
      chk("poll cleared", 0, q[POLL_BIT]);
      idx += n;
      tot += n;
      chk("sends", tot, u_tdp_mem_model.sends);
      bus(0, ADDR_STATUS, 4'hF, 0);
      chk("index", idx, q[7:0]);
      chk("busy", 0, q[8]);
      $display("poll round %0d done", r);
    end
    stop_test;
  end
endmodule
bind tdp_tx_poll tdp_monitor u_tdp_monitor (.clk, .reset, .avs_address, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_waitrequest, .mem_address, .mem_read,
  .mem_readdata, .mem_waitrequest, .send_start, .send_done, .crc32_select);
